// *** include/rat_consts.vh ***
// Constants for the alarm output and oscillator trim block
`ifndef RAT_CONSTS_VH
`define RAT_CONSTS_VH

// Register addresses on the internal register port
`define RAT_ADDR_W 5
`define RAT_ADDR_CTRL 5'h07
`define RAT_ADDR_TRIM 5'h08
`define RAT_ADDR_ALM0_WKDAY 5'h0D
`define RAT_ADDR_ALM1_WKDAY 5'h14

// Reset values
`define RAT_CTRL_RST 8'h80
`define RAT_TRIM_RST 8'h00
`define RAT_WKDAY_RST 8'h00
`define RAT_FIELD3_RST 3'h0
`define RAT_RDATA_ZERO 8'h00

// Control register fields
`define RAT_CTRL_OUT 7
`define RAT_CTRL_SQUARE_WAVE_ENABLE 6
`define RAT_CTRL_SECOND_ALARM_ENABLE 5
`define RAT_CTRL_FIRST_ALARM_ENABLE 4
`define RAT_CTRL_EXTERNAL_CLOCK_INPUT_ENABLE 3
`define RAT_CTRL_COARSE_TRIM_MODE 2
`define RAT_CTRL_RATE_HI 1
`define RAT_CTRL_RATE_LO 0

// Trim register fields
`define RAT_TRIM_SIGN 7
`define RAT_TRIM_MAG_HI 6
`define RAT_TRIM_MAG_LO 0
`define RAT_TRIM_MAG_ZERO 7'h00

// Alarm weekday/mask register fields
`define RAT_WK_POL 7
`define RAT_WK_MASK_HI 6
`define RAT_WK_MASK_LO 4
`define RAT_WK_FLAG 3
`define RAT_WK_DAY_HI 2
`define RAT_WK_DAY_LO 0

// Timebase: 32768 oscillator cycles per second, 256 per coarse slot
`define RAT_PRESC_W 15
`define RAT_PRESC_ZERO 15'h0000
`define RAT_SUM_ONE 16'h0001
`define RAT_SUM_ZERO 16'h0000
`define RAT_SLOT_LAST 8'hFF
`define RAT_SEC_W 6
`define RAT_SEC_ZERO 6'h00
`define RAT_SEC_ONE 6'h01
`define RAT_SEC_LAST 6'h3B
`define RAT_SKIP_ZERO 8'h00
`define RAT_SKIP_ONE 8'h01

`endif

// *** hdl/rat_trim_timebase.v ***
// Oscillator divider with per-minute or coarse 128 Hz digital trimming
`timescale 1ns/1ps
`include "rat_consts.vh"

module rat_trim_timebase (
  input wire clk_i,               // System clock
  input wire rst_n_i,             // Async reset, active low
  input wire osc_tick_i,          // One oscillator cycle
  input wire trim_sign_i,         // 1 add cycles, 0 remove cycles
  input wire [6:0] trim_mag_i,    // Trim magnitude, two cycles per unit
  input wire coarse_i,            // Coarse trim mode
  output reg second_tick_o,       // Trimmed one-second pulse
  output reg minute_tick_o,       // Trimmed one-minute pulse
  output reg slot_tick_o,         // Trimmed 128 Hz pulse
  output reg wave_64hz_o,         // Trimmed 64 Hz square wave
  output reg adjust_o             // Pulse when a trim adjustment is applied
);

  reg [`RAT_PRESC_W-1:0] presc_q, presc_d;
  reg [`RAT_SEC_W-1:0] sec_q, sec_d;
  reg [7:0] skip_q, skip_d;
  reg pend_q, pend_d;
  reg [15:0] sum;
  reg [15:0] add_amt;
  reg trig;
  reg sec_evt;
  reg min_evt;
  reg slot_evt;
  reg adj_evt;
  wire trim_on;
  wire [7:0] cycles;

  assign trim_on = (trim_mag_i != `RAT_TRIM_MAG_ZERO);
  assign cycles = {trim_mag_i, 1'b0};

  always @* begin
    presc_d = presc_q;
    sec_d = sec_q;
    skip_d = skip_q;
    pend_d = pend_q;
    sum = `RAT_SUM_ZERO;
    add_amt = `RAT_SUM_ZERO;
    trig = 1'b0;
    sec_evt = 1'b0;
    min_evt = 1'b0;
    slot_evt = 1'b0;
    adj_evt = 1'b0;
    if (osc_tick_i) begin
      if (skip_q != `RAT_SKIP_ZERO) begin
        // Swallowed cycle: divider stands still
        skip_d = skip_q - `RAT_SKIP_ONE;
      end else begin
        if (coarse_i) begin
          trig = trim_on && (presc_q[7:0] == `RAT_SLOT_LAST);
        end else begin
          trig = trim_on && pend_q;
        end
        if (trig || !trim_on || coarse_i) begin
          pend_d = 1'b0;
        end
        if (trig && trim_sign_i) begin
          add_amt = {8'h00, cycles};
        end
        if (trig && !trim_sign_i) begin
          skip_d = cycles;
        end
        adj_evt = trig;
        sum = {1'b0, presc_q} + `RAT_SUM_ONE + add_amt;
        presc_d = sum[`RAT_PRESC_W-1:0];
        slot_evt = (presc_q[7:0] == `RAT_SLOT_LAST) || trig;
        sec_evt = sum[`RAT_PRESC_W];
        if (sec_evt) begin
          if (sec_q == `RAT_SEC_LAST) begin
            sec_d = `RAT_SEC_ZERO;
            min_evt = 1'b1;
            pend_d = trim_on && !coarse_i;
          end else begin
            sec_d = sec_q + `RAT_SEC_ONE;
          end
        end
      end
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_q <= `RAT_PRESC_ZERO;
      sec_q <= `RAT_SEC_ZERO;
      skip_q <= `RAT_SKIP_ZERO;
      pend_q <= 1'b0;
      second_tick_o <= 1'b0;
      minute_tick_o <= 1'b0;
      slot_tick_o <= 1'b0;
      wave_64hz_o <= 1'b0;
      adjust_o <= 1'b0;
    end else begin
      presc_q <= presc_d;
      sec_q <= sec_d;
      skip_q <= skip_d;
      pend_q <= pend_d;
      second_tick_o <= sec_evt;
      minute_tick_o <= min_evt;
      slot_tick_o <= slot_evt;
      adjust_o <= adj_evt;
      if (slot_evt) begin
        wave_64hz_o <= ~wave_64hz_o;
      end
    end
  end

endmodule

// *** hdl/rat_mfp_select.v ***
// Level selection for the multi-function output pin
`timescale 1ns/1ps
`include "rat_consts.vh"

module rat_mfp_select (
  input wire square_wave_enable_i,    // Square wave mode
  input wire square_wave_i,           // Square wave level
  input wire first_alarm_enable_i,    // Alarm 0 enabled
  input wire second_alarm_enable_i,   // Alarm 1 enabled
  input wire first_alarm_flag_i,      // Alarm 0 flag
  input wire second_alarm_flag_i,     // Alarm 1 flag
  input wire alarm_output_polarity_i, // Alarm polarity
  input wire gp_level_i,              // General purpose level
  output reg pin_level_o              // Wanted pin level
);

  always @* begin
    pin_level_o = gp_level_i;
    if (square_wave_enable_i) begin
      pin_level_o = square_wave_i;
    end else if (first_alarm_enable_i && second_alarm_enable_i) begin
      if (alarm_output_polarity_i) begin
        pin_level_o = first_alarm_flag_i | second_alarm_flag_i;
      end else begin
        pin_level_o = ~(first_alarm_flag_i & second_alarm_flag_i);
      end
    end else if (first_alarm_enable_i) begin
      pin_level_o = alarm_output_polarity_i ? first_alarm_flag_i : ~first_alarm_flag_i;
    end else if (second_alarm_enable_i) begin
      pin_level_o = alarm_output_polarity_i ? second_alarm_flag_i : ~second_alarm_flag_i;
    end
  end

endmodule

// *** hdl/rat_top.v ***
// Alarm output pin control, register file and digital trim of the clock timebase
`timescale 1ns/1ps
`include "rat_consts.vh"

module rat_top (
  input wire clk_i,                            // System clock, 250 MHz
  input wire rst_n_i,                          // Async reset, active low
  input wire osc_tick_i,                       // One pulse per oscillator cycle
  input wire [`RAT_ADDR_W-1:0] reg_addr_i,     // Register address
  input wire [7:0] reg_wdata_i,                // Register write data
  input wire reg_wr_i,                         // Register write strobe
  input wire reg_rd_i,                         // Register read strobe
  output reg [7:0] reg_rdata_o,                // Register read data
  output reg reg_rvalid_o,                     // Read data valid pulse
  input wire first_alarm_match_i,              // Alarm 0 match event
  input wire second_alarm_match_i,             // Alarm 1 match event
  input wire square_wave_i,                    // Square wave from divider
  input wire multi_function_pin_i,             // Pin level read back
  output reg multi_function_pin_o,             // Pin drive value, always low
  output reg multi_function_pin_oe_o,          // Pin pulled low while high
  output reg square_wave_enable_o,             // Square wave mode
  output reg [1:0] square_wave_rate_select_o,  // Square wave rate
  output reg external_clock_input_enable_o,    // External clock input
  output reg coarse_trim_mode_o,               // Coarse trim mode
  output reg [2:0] first_alarm_mask_o,         // Alarm 0 match mode
  output reg [2:0] second_alarm_mask_o,        // Alarm 1 match mode
  output reg [2:0] first_alarm_weekday_o,      // Alarm 0 weekday
  output reg [2:0] second_alarm_weekday_o,     // Alarm 1 weekday
  output wire second_tick_o,                   // Trimmed one-second pulse
  output wire minute_tick_o,                   // Trimmed one-minute pulse
  output wire slot_tick_o,                     // Trimmed 128 Hz pulse
  output wire wave_64hz_o,                     // Trimmed 64 Hz wave
  output wire trim_adjust_o                    // Trim applied pulse
);

  reg [7:0] ctrl_q;
  reg [7:0] trim_q;
  reg [2:0] alm0_mask_q;
  reg [2:0] alm1_mask_q;
  reg [2:0] alm0_day_q;
  reg [2:0] alm1_day_q;
  reg polarity_q;
  reg first_alarm_flag_q, first_alarm_flag_d;
  reg second_alarm_flag_q, second_alarm_flag_d;
  reg [7:0] rdata_d;
  wire wr_ctrl;
  wire wr_trim;
  wire wr_alm0;
  wire wr_alm1;
  wire pin_level;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == `RAT_ADDR_CTRL);
  assign wr_trim = reg_wr_i && (reg_addr_i == `RAT_ADDR_TRIM);
  assign wr_alm0 = reg_wr_i && (reg_addr_i == `RAT_ADDR_ALM0_WKDAY);
  assign wr_alm1 = reg_wr_i && (reg_addr_i == `RAT_ADDR_ALM1_WKDAY);

  // Configuration registers
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `RAT_CTRL_RST;
      trim_q <= `RAT_TRIM_RST;
      alm0_mask_q <= `RAT_FIELD3_RST;
      alm1_mask_q <= `RAT_FIELD3_RST;
      alm0_day_q <= `RAT_FIELD3_RST;
      alm1_day_q <= `RAT_FIELD3_RST;
      polarity_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_i;
      end
      if (wr_trim) begin
        trim_q <= reg_wdata_i;
      end
      if (wr_alm0) begin
        polarity_q <= reg_wdata_i[`RAT_WK_POL];
        alm0_mask_q <= reg_wdata_i[`RAT_WK_MASK_HI:`RAT_WK_MASK_LO];
        alm0_day_q <= reg_wdata_i[`RAT_WK_DAY_HI:`RAT_WK_DAY_LO];
      end
      if (wr_alm1) begin
        alm1_mask_q <= reg_wdata_i[`RAT_WK_MASK_HI:`RAT_WK_MASK_LO];
        alm1_day_q <= reg_wdata_i[`RAT_WK_DAY_HI:`RAT_WK_DAY_LO];
      end
    end
  end

  // Alarm flags: match sets, any write to the weekday register clears; set wins
  always @* begin
    first_alarm_flag_d = first_alarm_flag_q;
    second_alarm_flag_d = second_alarm_flag_q;
    if (wr_alm0) begin
      first_alarm_flag_d = 1'b0;
    end
    if (wr_alm1) begin
      second_alarm_flag_d = 1'b0;
    end
    if (first_alarm_match_i) begin
      first_alarm_flag_d = 1'b1;
    end
    if (second_alarm_match_i) begin
      second_alarm_flag_d = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_alarm_flag_q <= 1'b0;
      second_alarm_flag_q <= 1'b0;
    end else begin
      first_alarm_flag_q <= first_alarm_flag_d;
      second_alarm_flag_q <= second_alarm_flag_d;
    end
  end

  // Read data mux; unmapped addresses read zero
  always @* begin
    rdata_d = `RAT_RDATA_ZERO;
    case (reg_addr_i)
      `RAT_ADDR_CTRL: begin
        rdata_d = ctrl_q;
      end
      `RAT_ADDR_TRIM: begin
        rdata_d = trim_q;
      end
      `RAT_ADDR_ALM0_WKDAY: begin
        rdata_d = {polarity_q, alm0_mask_q, first_alarm_flag_q, alm0_day_q};
      end
      `RAT_ADDR_ALM1_WKDAY: begin
        rdata_d = {polarity_q, alm1_mask_q, second_alarm_flag_q, alm1_day_q};
      end
      default: begin
        rdata_d = `RAT_RDATA_ZERO;
      end
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= `RAT_RDATA_ZERO;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

  // Digital trim of the oscillator divider
  rat_trim_timebase u_timebase (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .osc_tick_i(osc_tick_i),
    .trim_sign_i(trim_q[`RAT_TRIM_SIGN]),
    .trim_mag_i(trim_q[`RAT_TRIM_MAG_HI:`RAT_TRIM_MAG_LO]),
    .coarse_i(ctrl_q[`RAT_CTRL_COARSE_TRIM_MODE]),
    .second_tick_o(second_tick_o),
    .minute_tick_o(minute_tick_o),
    .slot_tick_o(slot_tick_o),
    .wave_64hz_o(wave_64hz_o),
    .adjust_o(trim_adjust_o)
  );

  // Pin mode selection
  rat_mfp_select u_mfp_select (
    .square_wave_enable_i(ctrl_q[`RAT_CTRL_SQUARE_WAVE_ENABLE]),
    .square_wave_i(square_wave_i),
    .first_alarm_enable_i(ctrl_q[`RAT_CTRL_FIRST_ALARM_ENABLE]),
    .second_alarm_enable_i(ctrl_q[`RAT_CTRL_SECOND_ALARM_ENABLE]),
    .first_alarm_flag_i(first_alarm_flag_q),
    .second_alarm_flag_i(second_alarm_flag_q),
    .alarm_output_polarity_i(polarity_q),
    .gp_level_i(ctrl_q[`RAT_CTRL_OUT]),
    .pin_level_o(pin_level)
  );

  // Open-drain pin: pull low for a low level, release for high
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      multi_function_pin_o <= 1'b0;
      multi_function_pin_oe_o <= 1'b0;
    end else begin
      multi_function_pin_o <= 1'b0;
      multi_function_pin_oe_o <= ~pin_level;
    end
  end

  // Configuration mirrors for neighbouring blocks
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      square_wave_enable_o <= 1'b0;
      square_wave_rate_select_o <= 2'h0;
      external_clock_input_enable_o <= 1'b0;
      coarse_trim_mode_o <= 1'b0;
      first_alarm_mask_o <= 3'h0;
      second_alarm_mask_o <= 3'h0;
      first_alarm_weekday_o <= 3'h0;
      second_alarm_weekday_o <= 3'h0;
    end else begin
      square_wave_enable_o <= ctrl_q[`RAT_CTRL_SQUARE_WAVE_ENABLE];
      square_wave_rate_select_o <= ctrl_q[`RAT_CTRL_RATE_HI:`RAT_CTRL_RATE_LO];
      external_clock_input_enable_o <= ctrl_q[`RAT_CTRL_EXTERNAL_CLOCK_INPUT_ENABLE];
      coarse_trim_mode_o <= ctrl_q[`RAT_CTRL_COARSE_TRIM_MODE];
      first_alarm_mask_o <= alm0_mask_q;
      second_alarm_mask_o <= alm1_mask_q;
      first_alarm_weekday_o <= alm0_day_q;
      second_alarm_weekday_o <= alm1_day_q;
    end
  end

endmodule

// *** verif/rat_host_model.sv ***
// Host side of the open-drain pin with its pull-up
`timescale 1ns/1ps

module rat_host_model (
  input wire oe_i,  // Device pulls pin low
  output wire pin_o // Level the host sees
);
  assign pin_o = oe_i ? 1'b0 : 1'b1;
endmodule

// *** verif/rat_checker.sv ***
// Port checker for pin modes, register reads and trim pulses
`timescale 1ns/1ps
`include "rat_consts.vh"

module rat_checker (
  input wire clk_i,                        // Clock
  input wire rst_n_i,                      // Reset, active low
  input wire [`RAT_ADDR_W-1:0] reg_addr_i, // Address
  input wire [7:0] reg_wdata_i,            // Write data
  input wire reg_wr_i,                     // Write strobe
  input wire reg_rd_i,                     // Read strobe
  input wire [7:0] reg_rdata_o,            // Read data
  input wire reg_rvalid_o,                 // Read valid
  input wire first_alarm_match_i,          // Alarm 0 match
  input wire second_alarm_match_i,         // Alarm 1 match
  input wire square_wave_i,                // Square wave
  input wire multi_function_pin_o,         // Pin drive
  input wire multi_function_pin_oe_o,      // Pin enable
  input wire trim_adjust_o                 // Trim pulse
);
  reg [7:0] ctl_q;
  reg [7:0] trim_q;
  reg pol_q;
  reg f0_q;
  reg f1_q;
  wire w0 = reg_wr_i && reg_addr_i == `RAT_ADDR_ALM0_WKDAY;
  wire w1 = reg_wr_i && reg_addr_i == `RAT_ADDR_ALM1_WKDAY;
  wire sq = ctl_q[`RAT_CTRL_SQUARE_WAVE_ENABLE];
  wire e1 = ctl_q[`RAT_CTRL_SECOND_ALARM_ENABLE];
  wire e0 = ctl_q[`RAT_CTRL_FIRST_ALARM_ENABLE];
  wire one_f = e0 ? f0_q : f1_q;
  wire oe = multi_function_pin_oe_o;
  wire mapped = reg_addr_i == `RAT_ADDR_CTRL || reg_addr_i == `RAT_ADDR_TRIM || w0 || w1 ||
                reg_addr_i == `RAT_ADDR_ALM0_WKDAY || reg_addr_i == `RAT_ADDR_ALM1_WKDAY;

  // Shadow of the registers that steer the pin and the trim
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_q <= `RAT_CTRL_RST;
      trim_q <= `RAT_TRIM_RST;
      pol_q <= 1'b0;
      f0_q <= 1'b0;
      f1_q <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == `RAT_ADDR_CTRL) ctl_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `RAT_ADDR_TRIM) trim_q <= reg_wdata_i;
      if (w0) pol_q <= reg_wdata_i[`RAT_WK_POL];
      f0_q <= first_alarm_match_i | (f0_q & !w0);
      f1_q <= second_alarm_match_i | (f1_q & !w1);
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  drive_low_a: assert property (!multi_function_pin_o) else $error("pin drive not low");
  read_valid_a: assert property (1'b1 |=> reg_rvalid_o == $past(reg_rd_i)) else $error("rvalid wrong");
  trim_read_a: assert property (reg_rd_i && reg_addr_i == `RAT_ADDR_TRIM |=> reg_rdata_o == $past(trim_q))
    else $error("trim read wrong");
  unmapped_read_a: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 8'h00) else $error("unmapped read");
  gp_level_a: assert property (!sq && !e0 && !e1 |=> oe == !$past(ctl_q[`RAT_CTRL_OUT])) else $error("gp level");
  one_alarm_a: assert property (!sq && (e0 ^ e1) |=> oe == ($past(pol_q) ^ $past(one_f)))
    else $error("single alarm level");
  both_or_a: assert property (!sq && e0 && e1 && pol_q |=> oe == !($past(f0_q) || $past(f1_q)))
    else $error("dual alarm or");
  both_nand_a: assert property (!sq && e0 && e1 && !pol_q |=> oe == ($past(f0_q) && $past(f1_q)))
    else $error("dual alarm nand");
  square_over_a: assert property (sq |=> oe == !$past(square_wave_i)) else $error("square wave");
  no_trim_a: assert property ((trim_q[6:0] == 7'h00) [*3] |-> !trim_adjust_o) else $error("trim at zero");
endmodule

bind rat_top rat_checker u_chk (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .reg_rvalid_o, .first_alarm_match_i, .second_alarm_match_i, .square_wave_i,
  .multi_function_pin_o, .multi_function_pin_oe_o, .trim_adjust_o);

// *** verif/rtc_alarm_output_and_trim_bench.sv ***
// Self-checking bench for the pin modes, registers and coarse trim
`timescale 1ns/1ps
`include "rat_consts.vh"

module rtc_alarm_output_and_trim_bench;
  reg clk_i, rst_n_i, osc_tick_i, reg_wr_i, reg_rd_i, square_wave_i;
  reg first_alarm_match_i, second_alarm_match_i;
  reg [`RAT_ADDR_W-1:0] reg_addr_i;
  reg [7:0] reg_wdata_i;
  wire [7:0] reg_rdata_o;
  wire reg_rvalid_o, pin_oe, pin_lvl, slot_tick_o, trim_adjust_o;
  integer mismatches, compares, i, adj, adj0;
  reg wv;
  wire sqe_o, ext_o, crs_o, w64_o;
  wire [1:0] rate_o;
  wire [2:0] m0_o, m1_o, d0_o, d1_o;
  reg [31:0] seed;
  reg [15:0] g;
  reg [7:0] tv [0:7];
  reg cs [0:7];

  rat_top DUT (.clk_i, .rst_n_i, .osc_tick_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .reg_rvalid_o, .first_alarm_match_i, .second_alarm_match_i, .square_wave_i,
    .multi_function_pin_i(pin_lvl), .multi_function_pin_o(), .multi_function_pin_oe_o(pin_oe),
    .square_wave_enable_o(sqe_o), .square_wave_rate_select_o(rate_o), .external_clock_input_enable_o(ext_o),
    .coarse_trim_mode_o(crs_o), .first_alarm_mask_o(m0_o), .second_alarm_mask_o(m1_o), .first_alarm_weekday_o(d0_o),
    .second_alarm_weekday_o(d1_o), .second_tick_o(), .minute_tick_o(), .slot_tick_o, .wave_64hz_o(w64_o),
    .trim_adjust_o);
  rat_host_model HOST (.oe_i(pin_oe), .pin_o(pin_lvl));

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function exp_pin(input s, a0, a1, p, g0, g1, o, w);
    if (s) exp_pin = w;
    else if (a0 && a1) exp_pin = p ? (g0 | g1) : !(g0 & g1);
    else if (a0 || a1) exp_pin = p ~^ (a0 ? g0 : g1);
    else exp_pin = o;
  endfunction

  // Slot period in oscillator ticks, one tick per clock here
  function [15:0] exp_gap(input [7:0] t, input c);
    if (!c || t[6:0] == 7'h00) exp_gap = 16'h0100;
    else if (t[7]) exp_gap = 16'h0100 - {t[6:0], 1'b0};
    else exp_gap = 16'h0100 + {t[6:0], 1'b0};
  endfunction

  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  task chk(input string n, input [15:0] e, input [15:0] s);
    begin
      compares = compares + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
    end
  endtask

  task wr(input [`RAT_ADDR_W-1:0] a, input [7:0] d);
    begin
      @(negedge clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clk_i);
      reg_wr_i = 1'b0;
    end
  endtask

  task rd(input [`RAT_ADDR_W-1:0] a, input [7:0] e);
    begin
      @(negedge clk_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clk_i);
      reg_rd_i = 1'b0;
      chk("rdata", {8'h00, e}, {8'h00, reg_rdata_o});
    end
  endtask

  task wslot;
    begin
      g = 16'h0000;
      do begin
        @(negedge clk_i);
        g = g + 16'h0001;
      end while (slot_tick_o !== 1'b1 && g < 16'h07D0);
      if (g >= 16'h07D0) begin
        mismatches = mismatches + 1;
        tally_and_finish;
      end
    end
  endtask

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) adj <= 0;
    else if (trim_adjust_o === 1'b1) adj <= adj + 1;
  end

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, square_wave_i, first_alarm_match_i, second_alarm_match_i} = 6'h00;
    osc_tick_i = 1'b1;
    reg_addr_i = 5'h00;
    reg_wdata_i = 8'h00;
    mismatches = 0;
    compares = 0;
    seed = 32'hE124;
    {tv[0], tv[1], tv[2], tv[3], tv[4], tv[5], tv[6]} = 56'h00_80_81_01_FF_7F_FF;
    {cs[0], cs[1], cs[2], cs[3], cs[4], cs[5], cs[6], cs[7]} = 8'hFD;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("pin", 16'h0001, {15'h0000, pin_lvl});
    rd(`RAT_ADDR_CTRL, `RAT_CTRL_RST);
    rd(`RAT_ADDR_TRIM, 8'h00);
    rd(`RAT_ADDR_ALM0_WKDAY, 8'h00);
    wr(5'h1F, 8'hFF);
    rd(5'h1F, 8'h00);
    seed = lfsr(seed);
    wr(`RAT_ADDR_TRIM, seed[7:0]);
    rd(`RAT_ADDR_TRIM, seed[7:0]);
    wr(`RAT_ADDR_ALM0_WKDAY, 8'h08);
    rd(`RAT_ADDR_ALM0_WKDAY, 8'h00);
    first_alarm_match_i = 1'b1;
    @(negedge clk_i);
    first_alarm_match_i = 1'b0;
    rd(`RAT_ADDR_ALM0_WKDAY, 8'h08);
    seed = lfsr(seed);
    wr(`RAT_ADDR_ALM0_WKDAY, seed[23:16]);
    wr(`RAT_ADDR_ALM1_WKDAY, seed[15:8]);
    wr(`RAT_ADDR_CTRL, {seed[7:6], 2'h0, seed[3:0]});
    @(negedge clk_i);
    chk("ctrl mirror", {11'h000, seed[6], seed[1:0], seed[3:2]}, {11'h000, sqe_o, rate_o, ext_o, crs_o});
    chk("alarm mirror", {4'h0, seed[22:20], seed[18:16], seed[14:12], seed[10:8]},
      {4'h0, m0_o, d0_o, m1_o, d1_o});
    rd(`RAT_ADDR_ALM0_WKDAY, {seed[23], seed[22:20], 1'b0, seed[18:16]});
    rd(`RAT_ADDR_ALM1_WKDAY, {seed[23], seed[14:12], 1'b0, seed[10:8]});
    for (i = 0; i < 64; i = i + 1) begin
      seed = lfsr(seed);
      wr(`RAT_ADDR_ALM0_WKDAY, {i[3], 7'h00});
      wr(`RAT_ADDR_ALM1_WKDAY, 8'h00);
      wr(`RAT_ADDR_CTRL, {seed[0], i[5:3] & 3'h7, 4'h0});
      wr(`RAT_ADDR_CTRL, {seed[0], i[5], i[4], i[2], 4'h0});
      square_wave_i = seed[1];
      first_alarm_match_i = i[1];
      second_alarm_match_i = i[0];
      @(negedge clk_i);
      {first_alarm_match_i, second_alarm_match_i} = 2'h0;
      repeat (3) @(negedge clk_i);
      chk("pin", {15'h0000, exp_pin(i[5], i[2], i[4], i[3], i[1], i[0], seed[0], seed[1])},
        {15'h0000, pin_lvl});
    end
    seed = lfsr(seed);
    tv[7] = seed[7:0];
    wr(`RAT_ADDR_TRIM, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      wr(`RAT_ADDR_CTRL, {5'h00, cs[i], 2'h0});
      wr(`RAT_ADDR_TRIM, tv[i]);
      wslot;
      wslot;
      wslot;
      adj0 = adj;
      wv = w64_o;
      wslot;
      chk("gap", exp_gap(tv[i], cs[i]), g);
      chk("adjust", {15'h0000, cs[i] && tv[i][6:0] != 7'h00}, adj[15:0] - adj0[15:0]);
      chk("wave", {15'h0000, ~wv}, {15'h0000, w64_o});
    end
    tally_and_finish;
  end
endmodule
